// ===== logic/qcs_top.sv
// four-channel clocked-strobe serial transmit and receive engine
// assumes host port, buffers and serial logic share clk; serial inputs are sampled through two stages
//
// Overview of operation
// - serial words are 32 bits, least significant bit first, both ways
// - data changes on falling reference edge, sampled on rising edge
// - strobe rises on falling edge before first bit, drops after last
// - multi-word transfers go back to back with no idle bits
// - transmit reference clock runs freely, never gated by strobe or data
// - receiver captures using incoming clock and strobe
// - each channel direction owns a 128 by 32 buffer of long words
// - host writes are latched and released at once
// - buffer reads are prefetched; first read only primes the pipeline
// - transmitter keeps sending until its buffer is empty
// - start bit clears itself when transmission finishes
// - completed transmission raises channel interrupt when enabled
// - end of reception can raise an interrupt
// - per-source masks, a master enable, and readable buffer status
// - parallel fill writes one host word into all four transmit buffers
// - bit clock divided programmably from the 20 MHz source, normally by 4
// - divider source selectable as oscillator, first io pin, or host clock
// - all buffers run on the host clock whatever the bit rate
// - every buffer reads back host-written data intact for self-test
// - exactly one wait state on every host read, none on host writes
// - strobe rise starts bit count; full words go via holding register
// - strobe low ends reception: clear enable, flag interrupt, go idle
// - enabled mid-transfer, receiver waits for strobe low then high
// - with receive buffer full, an idle receiver stays idle until space frees
`timescale 1ns/100ps
module qcs_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rd_data,
  // interrupt request, active high
  output logic             irq,
  // alternate reference input
  input  wire logic        change_of_state_io0,
  // serial transmit
  output logic      [3:0]  tx_clk,
  output logic             tx_clk_oe,
  output logic      [3:0]  tx_strb,
  output logic      [3:0]  tx_data,
  // serial receive
  input  wire logic [3:0]  rx_clk,
  input  wire logic [3:0]  rx_strb,
  input  wire logic [3:0]  rx_data
);

  // address decoding of the eight buffer ports: {hit, index}
  // index 0..3 transmit buffers, 4..7 receive buffers
  function automatic logic [3:0] fifo_sel(input logic [7:0] a);
    if (a == qcs_pkg::OFS_FTX0) begin
      fifo_sel = 4'h8;
    end else if (a == qcs_pkg::OFS_FTX1) begin
      fifo_sel = 4'h9;
    end else if (a == qcs_pkg::OFS_FTX2) begin
      fifo_sel = 4'ha;
    end else if (a == qcs_pkg::OFS_FTX3) begin
      fifo_sel = 4'hb;
    end else if (a == qcs_pkg::OFS_FRX0) begin
      fifo_sel = 4'hc;
    end else if (a == qcs_pkg::OFS_FRX1) begin
      fifo_sel = 4'hd;
    end else if (a == qcs_pkg::OFS_FRX2) begin
      fifo_sel = 4'he;
    end else if (a == qcs_pkg::OFS_FRX3) begin
      fifo_sel = 4'hf;
    end else begin
      fifo_sel = 4'h0;
    end
  endfunction : fifo_sel

  // software registers
  logic [31:0] base_reg;
  logic [31:0] txc_reg;
  logic [31:0] txs_reg;
  logic [31:0] rxc_reg;
  logic [3:0]  txd_sts_reg;
  logic [3:0]  rxd_sts_reg;
  logic [31:0] rd_data_reg;
  logic        irq_reg;
  logic [31:0] pf_reg [0:7];

  // buffer wiring
  wire  [31:0] f_head [0:7];
  wire  [31:0] f_din  [0:7];
  wire  [7:0]  f_push;
  wire  [7:0]  f_pop;
  wire  [7:0]  f_empty;
  wire  [7:0]  f_full;
  wire  [7:0]  host_pop;

  // engine events
  wire  [3:0]  tx_load;
  wire  [3:0]  tx_done;
  wire  [3:0]  rx_push;
  wire  [3:0]  rx_end;
  wire  [31:0] rx_hold [0:3];

  // decoded host access
  wire  [3:0]  wr_sel;
  wire  [3:0]  rd_sel;
  wire         wr_fifo;
  wire         rd_fifo;
  wire         par_fill;
  wire  [31:0] stat_word;
  wire  [31:0] reg_rd_val;

  assign wr_sel   = fifo_sel(addr);
  assign rd_sel   = fifo_sel(addr);
  assign wr_fifo  = wr_stb & wr_sel[3];
  assign rd_fifo  = rd_stb & rd_sel[3];
  assign par_fill = txc_reg[qcs_pkg::TX_PAR_LOAD];

  // status bits visible for polled use
  assign stat_word = {irq_reg, 11'h000,
                      f_full[7:4], f_empty[7:4], f_empty[3:0],
                      rxd_sts_reg, txd_sts_reg};

  assign reg_rd_val =
    (addr == qcs_pkg::OFS_BASE) ? base_reg :
    (addr == qcs_pkg::OFS_TX)   ? txc_reg  :
    (addr == qcs_pkg::OFS_TXS)  ? txs_reg  :
    (addr == qcs_pkg::OFS_RX)   ? rxc_reg  :
    (addr == qcs_pkg::OFS_STAT) ? stat_word : 32'h0000_0000;

  // ---- buffers --------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < 8; f++) begin : g_fifo
      // a host pop loses to an engine pop of the same transmit buffer
      if (f < 4) begin : g_tx
        assign host_pop[f] = rd_fifo & (rd_sel[2:0] == 3'(f)) &
                             ~f_empty[f] & ~tx_load[f];
        assign f_push[f]   = wr_fifo & ((wr_sel[2:0] == 3'(f)) |
                             (par_fill & (wr_sel[2:0] == 3'h0)));
        assign f_din[f]    = wr_data;
        assign f_pop[f]    = tx_load[f] | host_pop[f];
      end else begin : g_rx
        assign host_pop[f] = rd_fifo & (rd_sel[2:0] == 3'(f)) &
                             ~f_empty[f];
        // received words take the cycle; a host write then is dropped
        assign f_push[f]   = rx_push[f-4] |
                             (wr_fifo & (wr_sel[2:0] == 3'(f)));
        assign f_din[f]    = rx_push[f-4] ? rx_hold[f-4] : wr_data;
        assign f_pop[f]    = host_pop[f];
      end
      qcs_fifo u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (f < 4 ? base_reg[qcs_pkg::BASE_RST_TX]
                      : base_reg[qcs_pkg::BASE_RST_RX]),
        .push  (f_push[f]),
        .din   (f_din[f]),
        .pop   (f_pop[f]),
        .head  (f_head[f]),
        .empty (f_empty[f]),
        .full  (f_full[f])
      );
      // prefetch: a read returns the word fetched at the previous read
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pf_reg[f] <= 32'h0000_0000;
        end else if (rd_fifo && rd_sel[2:0] == 3'(f)) begin
          pf_reg[f] <= host_pop[f] ? f_head[f] : 32'h0000_0000;
        end
      end
    end
  endgenerate

  // ---- register port --------------------------------------------------
  // writes complete in the strobe cycle, reads answer one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (rd_stb) begin
      rd_data_reg <= rd_fifo ? pf_reg[rd_sel[2:0]] : reg_rd_val;
    end else begin
      rd_data_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= 32'h0000_0000;
      txs_reg  <= qcs_pkg::TXS_RST;
    end else if (wr_stb && addr == qcs_pkg::OFS_BASE) begin
      base_reg <= wr_data & qcs_pkg::BASE_MASK;
    end else if (wr_stb && addr == qcs_pkg::OFS_TXS) begin
      txs_reg  <= wr_data & qcs_pkg::TXS_MASK;
    end
  end

  // start and enable bits: a software write wins over the self-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_reg <= 32'h0000_0000;
    end else if (wr_stb && addr == qcs_pkg::OFS_TX) begin
      txc_reg <= wr_data & qcs_pkg::TX_MASK;
    end else begin
      txc_reg <= txc_reg & ~{28'h0000000, tx_done};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_reg <= 32'h0000_0000;
    end else if (wr_stb && addr == qcs_pkg::OFS_RX) begin
      rxc_reg <= wr_data & qcs_pkg::RX_MASK;
    end else begin
      rxc_reg <= rxc_reg & ~{28'h0000000, rx_end};
    end
  end

  // sticky completion flags, write one to clear, a new event wins
  wire stat_wr;
  assign stat_wr = wr_stb & (addr == qcs_pkg::OFS_STAT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_sts_reg <= 4'h0;
      rxd_sts_reg <= 4'h0;
    end else begin
      txd_sts_reg <= (txd_sts_reg & ~(stat_wr ? wr_data[3:0] : 4'h0))
                     | tx_done;
      rxd_sts_reg <= (rxd_sts_reg & ~(stat_wr ? wr_data[7:4] : 4'h0))
                     | rx_end;
    end
  end

  // per-source masks under a master enable
  wire irq_any;
  assign irq_any = |(txd_sts_reg & txc_reg[qcs_pkg::TX_IEN +: 4]) |
                   |(rxd_sts_reg & rxc_reg[qcs_pkg::RX_IEN +: 4]) |
                   base_reg[qcs_pkg::BASE_ISET];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= base_reg[qcs_pkg::BASE_IEN] & irq_any;
    end
  end

  // ---- bit clock divider ----------------------------------------------
  logic [2:0]  cos_sync_reg;
  logic [11:0] div_cnt_reg;
  logic [3:0]  ref_clk_reg;
  logic        clk_oe_reg;
  wire         src_tick;
  wire  [11:0] div_eff;
  wire  [11:0] div_half;
  wire         fall_ev;

  // the io pin is slow against clk; two stages then an edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cos_sync_reg <= 3'h0;
    end else begin
      cos_sync_reg <= {cos_sync_reg[1:0], change_of_state_io0};
    end
  end

  // oscillator and host-clock choices both tick every clk here
  assign src_tick = (txs_reg[qcs_pkg::TXS_REF +: 2] == qcs_pkg::REF_PIN)
                    ? (cos_sync_reg[1] & ~cos_sync_reg[2]) : 1'b1;
  assign div_eff  = (txs_reg[11:0] < qcs_pkg::DIV_MIN) ?
                    qcs_pkg::DIV_MIN : txs_reg[11:0];
  assign div_half = div_eff >> 1;
  assign fall_ev  = src_tick & (div_cnt_reg == div_eff - 12'h001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 12'h000;
      ref_clk_reg <= 4'h0;
      clk_oe_reg  <= 1'b0;
    end else begin
      clk_oe_reg <= txc_reg[qcs_pkg::TX_CLK_EN];
      if (fall_ev) begin
        div_cnt_reg <= 12'h000;
        ref_clk_reg <= 4'h0;
      end else if (src_tick) begin
        div_cnt_reg <= div_cnt_reg + 12'h001;
        if (div_cnt_reg + 12'h001 == div_half) begin
          ref_clk_reg <= 4'hf;
        end
      end
    end
  end

  // ---- receive input sampling -----------------------------------------
  logic [11:0] rx_s1_reg;
  logic [11:0] rx_s2_reg;
  logic [3:0]  rx_clk_prev_reg;
  wire  [3:0]  rx_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_reg       <= 12'h000;
      rx_s2_reg       <= 12'h000;
      rx_clk_prev_reg <= 4'h0;
    end else begin
      rx_s1_reg       <= {rx_clk, rx_strb, rx_data};
      rx_s2_reg       <= rx_s1_reg;
      rx_clk_prev_reg <= rx_s2_reg[11:8];
    end
  end

  assign rx_rise = rx_s2_reg[11:8] & ~rx_clk_prev_reg;

  // ---- per-channel engines --------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_ch
      qcs_pkg::qcs_tx_state_t tx_st_reg;
      logic [31:0] tx_sh_reg;
      logic [4:0]  tx_cnt_reg;
      logic        tx_strb_reg;
      logic        tx_data_reg;
      wire         tx_last;

      assign tx_last    = (tx_cnt_reg == 5'h00);
      assign tx_load[c] = fall_ev & ~f_empty[c] &
        ((tx_st_reg == qcs_pkg::QCS_TX_IDLE && txc_reg[c]) ||
         (tx_st_reg == qcs_pkg::QCS_TX_SEND && tx_last));
      assign tx_done[c] = fall_ev & f_empty[c] & tx_last &
                          (tx_st_reg == qcs_pkg::QCS_TX_SEND);
      assign tx_strb[c] = tx_strb_reg;
      assign tx_data[c] = tx_data_reg;

      // every change happens with the falling reference edge
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_st_reg   <= qcs_pkg::QCS_TX_IDLE;
          tx_sh_reg   <= 32'h0000_0000;
          tx_cnt_reg  <= 5'h00;
          tx_strb_reg <= 1'b0;
          tx_data_reg <= 1'b0;
        end else if (tx_load[c]) begin
          tx_st_reg   <= qcs_pkg::QCS_TX_SEND;
          tx_sh_reg   <= f_head[c] >> 1;
          tx_data_reg <= f_head[c][0];
          tx_strb_reg <= 1'b1;
          tx_cnt_reg  <= qcs_pkg::LAST_BIT;
        end else if (tx_done[c]) begin
          tx_st_reg   <= qcs_pkg::QCS_TX_IDLE;
          tx_strb_reg <= 1'b0;
          tx_data_reg <= 1'b0;
        end else if (fall_ev && tx_st_reg == qcs_pkg::QCS_TX_SEND) begin
          tx_sh_reg   <= tx_sh_reg >> 1;
          tx_data_reg <= tx_sh_reg[0];
          tx_cnt_reg  <= tx_cnt_reg - 5'h01;
        end
      end

      qcs_pkg::qcs_rx_state_t rx_st_reg;
      logic [31:0] rx_sh_reg;
      logic [31:0] rx_hold_reg;
      logic [4:0]  rx_cnt_reg;
      logic        rx_strb_prev_reg;
      logic        rx_push_reg;
      wire         rx_en;
      wire         strb_now;
      wire         bit_now;
      wire         rx_last;

      assign rx_en      = rxc_reg[qcs_pkg::RX_EN + c];
      assign strb_now   = rx_s2_reg[4 + c];
      assign bit_now    = rx_s2_reg[c];
      assign rx_last    = (rx_cnt_reg == qcs_pkg::LAST_BIT);
      assign rx_end[c]  = rx_rise[c] & ~strb_now &
                          (rx_st_reg == qcs_pkg::QCS_RX_RECV);
      assign rx_push[c] = rx_push_reg;
      assign rx_hold[c] = rx_hold_reg;

      // free-running shift register, one bit per incoming rising edge
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_sh_reg        <= 32'h0000_0000;
          rx_strb_prev_reg <= 1'b0;
        end else if (rx_rise[c]) begin
          rx_sh_reg        <= {bit_now, rx_sh_reg[31:1]};
          rx_strb_prev_reg <= strb_now;
        end
      end

      // a word finished while the buffer is full is lost
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_st_reg   <= qcs_pkg::QCS_RX_IDLE;
          rx_cnt_reg  <= 5'h00;
          rx_hold_reg <= 32'h0000_0000;
          rx_push_reg <= 1'b0;
        end else begin
          rx_push_reg <= 1'b0;
          case (rx_st_reg)
            qcs_pkg::QCS_RX_IDLE: begin
              if (rx_en && !f_full[4 + c]) begin
                rx_st_reg <= strb_now ? qcs_pkg::QCS_RX_SKIP
                                      : qcs_pkg::QCS_RX_ARMED;
              end
            end
            qcs_pkg::QCS_RX_SKIP: begin
              if (!rx_en) begin
                rx_st_reg <= qcs_pkg::QCS_RX_IDLE;
              end else if (!strb_now) begin
                rx_st_reg <= qcs_pkg::QCS_RX_ARMED;
              end
            end
            qcs_pkg::QCS_RX_ARMED: begin
              if (!rx_en) begin
                rx_st_reg <= qcs_pkg::QCS_RX_IDLE;
              end else if (rx_rise[c] && strb_now && !rx_strb_prev_reg) begin
                rx_st_reg  <= qcs_pkg::QCS_RX_RECV;
                rx_cnt_reg <= 5'h01;
              end
            end
            qcs_pkg::QCS_RX_RECV: begin
              if (!rx_en || rx_end[c]) begin
                rx_st_reg <= qcs_pkg::QCS_RX_IDLE;
              end else if (rx_rise[c]) begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
                if (rx_last) begin
                  rx_hold_reg <= {bit_now, rx_sh_reg[31:1]};
                  rx_push_reg <= ~f_full[4 + c];
                end
              end
            end
            default: begin
              rx_st_reg <= qcs_pkg::QCS_RX_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  assign rd_data   = rd_data_reg;
  assign irq       = irq_reg;
  assign tx_clk    = ref_clk_reg;
  assign tx_clk_oe = clk_oe_reg;

endmodule : qcs_top

// ===== common/qcs_pkg.sv
// constants and types for the four-channel clocked-strobe serial engine
// assumes one clock for host port, buffers and serial logic
package qcs_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CH        = 4;
  localparam int NFIFO     = 8;
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W     = 7;
  localparam int CNT_W     = 8;
  localparam int BIT_CNT_W = 5;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_BASE = 8'h00;
  localparam logic [7:0] OFS_TX   = 8'h04;
  localparam logic [7:0] OFS_TXS  = 8'h08;
  localparam logic [7:0] OFS_RX   = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_FRX0 = 8'h20;
  localparam logic [7:0] OFS_FRX1 = 8'h24;
  localparam logic [7:0] OFS_FTX0 = 8'h28;
  localparam logic [7:0] OFS_FTX1 = 8'h2c;
  localparam logic [7:0] OFS_FTX2 = 8'h30;
  localparam logic [7:0] OFS_FTX3 = 8'h34;
  localparam logic [7:0] OFS_FRX2 = 8'h3c;
  localparam logic [7:0] OFS_FRX3 = 8'h40;

  // field positions
  localparam int BASE_IEN    = 0;
  localparam int BASE_ISET   = 1;
  localparam int BASE_RST_TX = 4;
  localparam int BASE_RST_RX = 8;
  localparam int TX_START    = 0;
  localparam int TX_IEN      = 4;
  localparam int TX_CLK_EN   = 9;
  localparam int TX_PAR_LOAD = 10;
  localparam int TXS_DIV     = 0;
  localparam int TXS_REF     = 13;
  localparam int RX_EN       = 0;
  localparam int RX_IEN      = 4;
  localparam int STAT_TXD    = 0;
  localparam int STAT_RXD    = 4;
  localparam int STAT_TXE    = 8;
  localparam int STAT_RXE    = 12;
  localparam int STAT_RXF    = 16;
  localparam int STAT_IRQ    = 31;

  // writable bits and values after reset
  localparam logic [31:0] BASE_MASK = 32'h0000_0113;
  localparam logic [31:0] TX_MASK   = 32'h0000_06ff;
  localparam logic [31:0] TXS_MASK  = 32'h0000_7fff;
  localparam logic [31:0] RX_MASK   = 32'h0000_00ff;
  localparam logic [31:0] TXS_RST   = 32'h0000_0004;
  localparam logic [11:0] DIV_MIN   = 12'h002;
  localparam logic [1:0]  REF_PIN   = 2'h2;
  localparam logic [4:0]  LAST_BIT  = 5'h1f;

  typedef enum logic [0:0] {
    QCS_TX_IDLE = 1'b0,
    QCS_TX_SEND = 1'b1
  } qcs_tx_state_t;

  typedef enum logic [1:0] {
    QCS_RX_IDLE  = 2'b00,
    QCS_RX_SKIP  = 2'b01,
    QCS_RX_ARMED = 2'b10,
    QCS_RX_RECV  = 2'b11
  } qcs_rx_state_t;

endpackage : qcs_pkg

// ===== logic/qcs_fifo.sv
// one 128 x 32 first-in first-out buffer in flip-flops
// a push when full or a pop when empty is ignored
`timescale 1ns/100ps
module qcs_fifo (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  // write side
  input  wire logic        push,
  input  wire logic [31:0] din,
  // read side, head shown ahead
  input  wire logic        pop,
  output logic      [31:0] head,
  output logic             empty,
  output logic             full
);
  logic [31:0]                mem_reg [0:qcs_pkg::FIFO_DEPTH-1];
  logic [qcs_pkg::PTR_W-1:0] wr_ptr_reg;
  logic [qcs_pkg::PTR_W-1:0] rd_ptr_reg;
  logic [qcs_pkg::CNT_W-1:0] count_reg;
  wire                        do_push;
  wire                        do_pop;

  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign head    = mem_reg[rd_ptr_reg];
  assign empty   = (count_reg == 8'h00);
  assign full    = (count_reg == 8'h80);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= din;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
      count_reg  <= 8'h00;
    end else if (clr) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
      count_reg  <= 8'h00;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + 7'(do_push);
      rd_ptr_reg <= rd_ptr_reg + 7'(do_pop);
      count_reg  <= count_reg + 8'(do_push) - 8'(do_pop);
    end
  end
endmodule : qcs_fifo

// ===== sim/qcs_top_monitor.sv
// checker on the top ports of the serial engine
// assumes the divisor stays at its reset value of four
`timescale 1ns/100ps
module qcs_top_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // host side
  input wire logic        rd_stb,
  input wire logic [31:0] rd_data,
  // serial transmit
  input wire logic [3:0]  tx_clk,
  input wire logic [3:0]  tx_strb,
  input wire logic [3:0]  tx_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // clocks of strobe high; a word is 128 at divide by four
  logic [8:0]  hi_cnt_reg;
  // clocks of reference low; counted, too long for a delay range
  logic [11:0] lo_cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_cnt_reg <= 9'h000;
    else hi_cnt_reg <= tx_strb[0] ? hi_cnt_reg + 9'h001 : 9'h000;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lo_cnt_reg <= 12'h000;
    else lo_cnt_reg <= tx_clk[0] ? 12'h000 : lo_cnt_reg + 12'h001;
  end
  a_rd_one_slot: assert property (!$past(rd_stb) |-> rd_data == 32'h0)
    else $error("read data outside its slot");
  a_strb_rise_fall: assert property ($rose(tx_strb[0]) |-> $fell(tx_clk[0]))
    else $error("strobe rose off the falling edge");
  a_strb_drop_fall: assert property ($fell(tx_strb[0]) |-> $fell(tx_clk[0]))
    else $error("strobe dropped off the falling edge");
  a_data_on_fall: assert property ($changed(tx_data[0]) |-> $fell(tx_clk[0]))
    else $error("data moved off the falling edge");
  a_clk_keeps_run: assert property (lo_cnt_reg < 12'h834)
    else $error("reference clock stalled");
  a_clk_lanes_same: assert property (tx_clk == {4{tx_clk[0]}})
    else $error("reference clocks differ");
  a_whole_words: assert property ($fell(tx_strb[0]) |->
    hi_cnt_reg[6:0] == 7'h00)
    else $error("frame not whole words");
  a_idle_data_low: assert property (!tx_strb[0] |-> !tx_data[0])
    else $error("data active outside frame");
  c_frame_end: cover property ($fell(tx_strb[0]));
  c_read: cover property ($rose(rd_stb));
  c_lane3_end: cover property ($fell(tx_strb[3]));
endmodule : qcs_top_monitor

bind qcs_top qcs_top_monitor qcs_top_monitor_inst (.clk(clk), .rst_n(rst_n),
  .rd_stb(rd_stb), .rd_data(rd_data), .tx_clk(tx_clk), .tx_strb(tx_strb),
  .tx_data(tx_data));

// ===== sim/qcs_link_model.sv
// far-end sender feeding two framed words into all receive lanes
// assumes clk is the device clock; link clock is clk/6, free running
`timescale 1ns/100ps
module qcs_link_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bench control
  input  wire logic        go,
  input  wire logic [31:0] base_word,
  output logic             busy,
  // receive pins of the device
  output logic      [3:0]  rx_clk,
  output logic      [3:0]  rx_strb,
  output logic      [3:0]  rx_data
);
  logic [2:0]  ph;
  logic [6:0]  left;
  logic [6:0]  pos;
  logic [31:0] w;
  assign rx_clk = {4{ph < 3'd3}};
  assign busy   = (left != 7'h00) || rx_strb[0];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 3'd0; left <= 7'h00; pos <= 7'h00;
      rx_strb <= 4'h0; rx_data <= 4'h0;
    end else begin
      ph <= (ph == 3'd5) ? 3'd0 : ph + 3'd1;
      if (go) begin
        left <= 7'h40; pos <= 7'h00;
      end else if (ph == 3'd2) begin
        if (left != 7'h00) begin
          rx_strb <= 4'hf;
          for (int i = 0; i < 4; i++) begin
            w = base_word + {31'h0, pos[5]} + 32'(i);
            rx_data[i] <= w[pos[4:0]];
          end
          pos <= pos + 7'h01; left <= left - 7'h01;
        end else begin
          rx_strb <= 4'h0;
          rx_data <= ~rx_data; // idle line toggles each link clock, no stale level
        end
      end
    end
  end
endmodule : qcs_link_model

// ===== sim/tb.sv
// self-checking bench: registers, loop-back, transmit and receive
// assumes the link model on the receive pins and the bound checker
`timescale 1ns/100ps
module tb;
  logic clk, rst_n, wr_stb, rd_stb, irq, cos_io, tx_clk_oe, go, busy;
  logic [7:0]  addr;
  logic [7:0]  ra [4];
  logic [31:0] wr_data, rd_data, rd_val, w0, w1, rw, sr;
  logic [31:0] cap [2];
  logic [3:0]  tx_clk, tx_strb, tx_data, rx_clk, rx_strb, rx_data;
  int          errors, n_checks, cyc, nb;
  qcs_top qcs_top_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .irq(irq), .change_of_state_io0(cos_io), .tx_clk(tx_clk),
    .tx_clk_oe(tx_clk_oe), .tx_strb(tx_strb), .tx_data(tx_data),
    .rx_clk(rx_clk), .rx_strb(rx_strb), .rx_data(rx_data));
  qcs_link_model qcs_link_model_inst (.clk(clk), .rst_n(rst_n), .go(go),
    .base_word(rw), .busy(busy), .rx_clk(rx_clk), .rx_strb(rx_strb),
    .rx_data(rx_data));
  always #25 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a; wr_data <= d; wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(nm, e, rd_data);
  endtask : rdchk
  function automatic logic [31:0] rx_word(int k, int ln);
    return rw + 32'(k) + 32'(ln);
  endfunction : rx_word
  always @(posedge clk) begin
    cos_io <= 1'($urandom);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // mid-bit sampling on the rising reference edge
  always @(posedge tx_clk[0]) if (tx_strb[0]) begin
    sr = {tx_data[0], sr[31:1]};
    nb++;
    chk("lane copy", {31'h0, tx_data[0]}, {31'h0, tx_data[3]});
    if (nb % 32 == 0 && nb <= 64) cap[nb / 32 - 1] = sr;
  end
  initial begin
    void'($urandom(55));
    clk = 0; rst_n = 0; addr = 0; wr_data = 0; wr_stb = 0; rd_stb = 0;
    go = 0; cos_io = 0; cyc = 0; nb = 0; errors = 0; n_checks = 0; sr = 0;
    ra = '{qcs_pkg::OFS_FRX0, qcs_pkg::OFS_FRX1, qcs_pkg::OFS_FRX2,
           qcs_pkg::OFS_FRX3};
    w0 = $urandom; w1 = 32'h8000_0001; rw = $urandom;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("divisor", qcs_pkg::OFS_TXS, qcs_pkg::TXS_RST);
    rdchk("unmapped", 8'h50, 32'h0);
    wr(qcs_pkg::OFS_BASE, 32'hffff_fffc);
    rdchk("base mask", qcs_pkg::OFS_BASE, 32'h0000_0110);
    wr(qcs_pkg::OFS_BASE, 32'h0);
    for (int k = 0; k < 3; k++) wr(qcs_pkg::OFS_FTX1, w0 ^ 32'(k));
    rdchk("prime", qcs_pkg::OFS_FTX1, 32'h0);
    for (int k = 0; k < 3; k++)
      rdchk("loop back", qcs_pkg::OFS_FTX1, w0 ^ 32'(k));
    wr(qcs_pkg::OFS_TX, 32'h0000_0400);
    wr(qcs_pkg::OFS_FTX0, w0);
    wr(qcs_pkg::OFS_FTX0, w1);
    wr(qcs_pkg::OFS_BASE, 32'h1);
    wr(qcs_pkg::OFS_TX, 32'h0000_02ff);
    for (int t = 0; t < 1000 && irq !== 1'b1; t++) @(posedge clk);
    #1 chk("tx irq", 32'h1, {31'h0, irq});
    chk("clock drive", 32'h1, {31'h0, tx_clk_oe});
    rdchk("tx status", qcs_pkg::OFS_STAT, 32'h8000_ff0f);
    rdchk("tx control", qcs_pkg::OFS_TX, 32'h0000_02f0);
    chk("word 0", w0, cap[0]);
    chk("word 1", w1, cap[1]);
    wr(qcs_pkg::OFS_STAT, 32'h0000_00ff);
    wr(qcs_pkg::OFS_TX, 32'h0);
    wr(qcs_pkg::OFS_RX, 32'h0000_00ff);
    chk("clock drive off", 32'h0, {31'h0, tx_clk_oe});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (5) @(posedge clk);
    for (int t = 0; t < 2000 && busy; t++) @(posedge clk);
    repeat (20) @(posedge clk);
    rdchk("rx status", qcs_pkg::OFS_STAT, 32'h8000_0ff0);
    rdchk("rx control", qcs_pkg::OFS_RX, 32'h0000_00f0);
    for (int l = 0; l < 4; l++) begin
      rdchk("rx prime", ra[l], 32'h0);
      for (int k = 0; k < 2; k++)
        rdchk("rx word", ra[l], rx_word(k, l));
    end
    tally_and_finish();
  end
endmodule : tb
